/* dv/etsr_chk.sv */
/*
  checker for the sample readout register port: idle data, reserved
  bits, phase codes and read-only hold of the seconds registers.
  assumes it is bound to etsr_sample_readout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "etsr_consts.vh"

module etsr_chk
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [1:0]  evt_pin,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr_stb,
  input wire logic        reg_rd_stb,
  input wire logic [31:0] reg_rdata_r
);
  logic [2:0] quiet_r;
  wire mapped = reg_addr == 16'h0510 ||
    (reg_addr >= 16'h059C && reg_addr <= 16'h05B8 && reg_addr[1:0] == 2'h0);
  wire r7s = reg_rd_stb && reg_addr == `ETSR_OFF_S7_SEC;
  wire w7s = reg_wr_stb && reg_addr == `ETSR_OFF_S7_SEC;
  wire r8s = reg_rd_stb && reg_addr == `ETSR_OFF_S8_SEC;
  wire w8s = reg_wr_stb && reg_addr == `ETSR_OFF_S8_SEC;

  // cycles since the pins last moved; a quiet pin means no sample update
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      quiet_r <= 3'h0;
    else if (evt_pin != $past(evt_pin))
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_rdata_idle: assert property (!reg_rd_stb |=> reg_rdata_r == 32'h0)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (reg_rd_stb && !mapped |=> reg_rdata_r == 32'h0)
    else $error("unmapped read not zero");
  a_ns_resv_bit: assert property (reg_rd_stb && (reg_addr == `ETSR_OFF_S7_NS ||
    reg_addr == `ETSR_OFF_S8_NS) |=> !reg_rdata_r[31])
    else $error("reserved ns bit set");
  a_phase7_code: assert property (reg_rd_stb && reg_addr == `ETSR_OFF_S7_PHASE
    |=> reg_rdata_r <= 32'h4)
    else $error("seventh phase code out of range");
  a_phase8_code: assert property (reg_rd_stb && reg_addr == `ETSR_OFF_S8_PHASE
    |=> reg_rdata_r <= 32'h4)
    else $error("eighth phase code out of range");
  a_sec7_hold: assert property ((quiet_r == 3'h7 && r7s) ##2 w7s ##2 r7s
    |=> reg_rdata_r == $past(reg_rdata_r, 4))
    else $error("seventh seconds changed by write");
  a_sec8_hold: assert property ((quiet_r == 3'h7 && r8s) ##2 w8s ##2 r8s
    |=> reg_rdata_r == $past(reg_rdata_r, 4))
    else $error("eighth seconds changed by write");
  a_ptr_layout: assert property (reg_rd_stb && reg_addr == 16'h0510
    |=> (reg_rdata_r & 32'hFFFFFEFF) == 32'h0)
    else $error("unit index reserved bits set");

  c_sec7_hold: cover property (r7s ##2 w7s ##2 r7s);
  c_sec8_read: cover property (r8s);
  c_pin_move:  cover property (quiet_r == 3'h0);
endmodule // etsr_chk

bind etsr_sample_readout etsr_chk u_chk
(
  .sys_clk     (sys_clk),
  .arst_n      (arst_n),
  .evt_pin     (evt_pin),
  .reg_addr    (reg_addr),
  .reg_wr_stb  (reg_wr_stb),
  .reg_rd_stb  (reg_rd_stb),
  .reg_rdata_r (reg_rdata_r)
);
`default_nettype wire

/* dv/etsr_evt_src.sv */
/*
  event source model standing on the two event pins.
  assumes toggle requests come from the bench on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module etsr_evt_src
(
  input  wire logic       sys_clk,
  input  wire logic [1:0] tgl_req,
  output var  logic [1:0] evt_pin
);
  // each request flips a level; levels hold between requests
  initial evt_pin = 2'h0;
  always @(posedge sys_clk)
    evt_pin <= evt_pin ^ tgl_req;
endmodule // etsr_evt_src
`default_nettype wire

/* dv/tb_top.sv */
/*
  top bench: register port master, event source, sample checks.
  assumes the readout block and the event source model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "etsr_consts.vh"

module tb_top;
  logic        sys_clk;
  logic        arst_n;
  logic        reg_wr_stb;
  logic        reg_rd_stb;
  logic [1:0]  tgl_req;
  logic [1:0]  evt_pin;
  logic [29:0] tod_nsec;
  logic [31:0] tod_sec;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata_r;
  logic [31:0] rd_d;
  logic [31:0] ph7;
  logic [31:0] u0s;
  logic [15:0] reg_addr;
  logic [29:0] ns_e [7:8];
  logic [31:0] s_e [7:8];
  int          err_total;
  int          checked;
  int          cyc = 0;
  int          sp;

  etsr_sample_readout u_etsr_sample_readout
  (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .evt_pin     (evt_pin),
    .tod_nsec    (tod_nsec),
    .tod_sec     (tod_sec),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr_stb  (reg_wr_stb),
    .reg_rd_stb  (reg_rd_stb),
    .reg_rdata_r (reg_rdata_r)
  );

  etsr_evt_src u_etsr_evt_src
  (
    .sys_clk (sys_clk),
    .tgl_req (tgl_req),
    .evt_pin (evt_pin)
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_wr_stb <= 1'b1;
    @(posedge sys_clk);
    reg_wr_stb <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(logic [15:0] a);
    @(posedge sys_clk);
    reg_addr   <= a;
    reg_rd_stb <= 1'b1;
    @(posedge sys_clk);
    reg_rd_stb <= 1'b0;
    #1 rd_d = reg_rdata_r;
  endtask

  function automatic logic [31:0] nsw(logic p, logic [29:0] n);
    return {1'b0, p, n};
  endfunction

  // n pin toggles; time of day held long enough to be taken
  task automatic run(int u, int n);
    int g;
    for (int k = 1; k <= n; k++)
    begin
      g = 5 + $urandom % 7;
      @(posedge sys_clk);
      tod_nsec   <= 30'($urandom % 32'h3B9ACA00);
      tod_sec    <= $urandom;
      tgl_req[u] <= 1'b1;
      @(posedge sys_clk);
      tgl_req[u] <= 1'b0;
      if (k == 7 || k == 8)
      begin
        ns_e[k] = tod_nsec;
        s_e[k]  = tod_sec;
      end
      if (k == 7)
        sp = g + 2;
      repeat (g) @(posedge sys_clk);
    end
  endtask

  task automatic chk_set(logic p7);
    logic [15:0] b;
    for (int k = 7; k <= 8; k++)
    begin
      b = (k == 7) ? `ETSR_OFF_S7_NS : `ETSR_OFF_S8_NS;
      rd(b);
      chk("sample ns", rd_d, nsw(p7 ^ (k == 8), ns_e[k]));
      rd(b + 16'h4);
      wr(b + 16'h4, $urandom);
      rd(b + 16'h4);
      chk("sample s", rd_d, s_e[k]);
    end
    rd(`ETSR_OFF_S7_PHASE);
    ph7 = rd_d;
    rd(`ETSR_OFF_S8_PHASE);
    chk("s8 phase", rd_d, 32'((ph7 + sp) % 5));
  endtask

  // ****************************************************************
  // clock, watchdog, main sequence
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // a hang ends in the same closing report
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    {arst_n, reg_wr_stb, reg_rd_stb, tgl_req} = 5'h0;
    {tod_nsec, tod_sec, reg_addr, reg_wdata} = 110'h0;
    err_total = 0;
    checked   = 0;
    void'($urandom(32'hc940a60f));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int a = 16'h059C; a <= 16'h05B0; a += 4)
    begin
      wr(16'(a), $urandom);
      rd(16'(a));
      chk("sample reset", rd_d, 32'h0);
    end
    rd(16'h05C0);
    chk("unmapped", rd_d, 32'h0);
    run(0, 8);
    chk_set(1'b1);
    u0s = s_e[7];
    wr(16'h0510, 32'h00000100);
    rd(16'h0510);
    chk("pointer", rd_d, 32'h00000100);
    rd(`ETSR_OFF_S7_SEC);
    chk("unit1 idle", rd_d, 32'h0);
    // ninth toggle must not disturb the frozen samples
    run(1, 9);
    chk_set(1'b1);
    wr(16'h0510, 32'h0);
    rd(`ETSR_OFF_S7_SEC);
    chk("unit0 kept", rd_d, u0s);
    wr(16'h0510, 32'h00000100);
    wr(`ETSR_OFF_CTRL, 32'h00000203);
    run(1, 8);
    chk_set(1'b0);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

/* rtl/etsr_capture_unit.v */
/*
  one timestamp unit: synchronises its event pin, counts edges and keeps
  the seventh and eighth edge samples (polarity, ns, s, phase code).
  assumes time-of-day and phase inputs come from logic on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "etsr_consts.vh"

module etsr_capture_unit
(
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        evt_pin,
  input  wire        cap_enable,
  input  wire        cap_clear,
  input  wire [29:0] tod_nsec,
  input  wire [31:0] tod_sec,
  input  wire [2:0]  phase_slot,
  output reg  [3:0]  edge_cnt_r,
  output reg         seventh_edge_polarity,
  output reg  [29:0] seventh_capture_nanosec,
  output reg  [31:0] seventh_capture_sec,
  output reg  [2:0]  seventh_capture_phase_slot,
  output reg         eighth_edge_polarity,
  output reg  [29:0] eighth_capture_nanosec,
  output reg  [31:0] eighth_capture_sec,
  output reg  [2:0]  eighth_capture_phase_slot
);

  // ****************************************************************
  // pin synchroniser and edge detect
  // ****************************************************************
  reg  sync1_r;
  reg  sync2_r;
  reg  prev_r;
  wire rise;
  wire fall;
  wire hit;

  // first stage feeds only the second stage
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= evt_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  // counting stops once eighth edge is held, so samples stay frozen
  assign hit  = cap_enable & (rise | fall) & (edge_cnt_r != `ETSR_CNT_FULL);

  // ****************************************************************
  // edge counter and sample slots
  // ****************************************************************
  // clear takes priority: software rearms the unit for a new burst
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      edge_cnt_r                 <= `ETSR_ZERO4;
      seventh_edge_polarity      <= 1'b0;
      seventh_capture_nanosec    <= `ETSR_ZERO30;
      seventh_capture_sec        <= `ETSR_ZERO32;
      seventh_capture_phase_slot <= `ETSR_ZERO3;
      eighth_edge_polarity       <= 1'b0;
      eighth_capture_nanosec     <= `ETSR_ZERO30;
      eighth_capture_sec         <= `ETSR_ZERO32;
      eighth_capture_phase_slot  <= `ETSR_ZERO3;
    end
    else if (cap_clear)
    begin
      edge_cnt_r <= `ETSR_ZERO4;
    end
    else if (hit)
    begin
      edge_cnt_r <= edge_cnt_r + 4'h1;
      if (edge_cnt_r == `ETSR_CNT_BEFORE_7TH)
      begin
        seventh_edge_polarity      <= rise;        // RULE2
        seventh_capture_nanosec    <= tod_nsec;    // RULE3
        seventh_capture_sec        <= tod_sec;     // RULE4
        seventh_capture_phase_slot <= phase_slot;  // RULE5
      end
      if (edge_cnt_r == `ETSR_CNT_BEFORE_8TH)
      begin
        eighth_edge_polarity      <= rise;         // RULE7
        eighth_capture_nanosec    <= tod_nsec;     // RULE7
        eighth_capture_sec        <= tod_sec;      // RULE7
        eighth_capture_phase_slot <= phase_slot;   // RULE8
      end
    end
  end

endmodule // etsr_capture_unit
`default_nettype wire

/* rtl/etsr_consts.vh */
/*
  constants for the event timestamp sample readout block: register byte
  offsets, field positions, reset values and capture counts.
  assumes it is included by bare name from files under rtl/ and dv/.
*/
`ifndef ETSR_CONSTS_VH
`define ETSR_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ETSR_ADDR_W          16
`define ETSR_OFF_UNIT_INDEX  16'h0510
`define ETSR_OFF_S7_NS       16'h059C
`define ETSR_OFF_S7_SEC      16'h05A0
`define ETSR_OFF_S7_PHASE    16'h05A4
`define ETSR_OFF_S8_NS       16'h05A8
`define ETSR_OFF_S8_SEC      16'h05AC
`define ETSR_OFF_S8_PHASE    16'h05B0
`define ETSR_OFF_CTRL        16'h05B4
`define ETSR_OFF_STATUS      16'h05B8

// ****************************************************************
// field positions and widths
// ****************************************************************
`define ETSR_UNIT_PTR_BIT    8
`define ETSR_EDGE_BIT        30
`define ETSR_NS_MSB          29
`define ETSR_PHASE_MSB       2
`define ETSR_CNT_MSB         3
`define ETSR_CTRL_CLR_LSB    8

// ****************************************************************
// reset values and counts
// ****************************************************************
`define ETSR_ZERO32          32'h00000000
`define ETSR_ZERO30          30'h00000000
`define ETSR_ZERO3           3'h0
`define ETSR_ZERO4           4'h0
`define ETSR_ENABLE_RST      2'h3
`define ETSR_SLOT_LAST       3'h4
`define ETSR_CNT_BEFORE_7TH  4'h6
`define ETSR_CNT_BEFORE_8TH  4'h7
`define ETSR_CNT_FULL        4'h8

`endif

/* rtl/etsr_sample_readout.v */
/*
  event timestamp sample readout: two timestamp units, the 8 ns phase
  slot counter and the register port through which software reads the
  seventh and eighth samples of the unit chosen by the unit pointer.
  assumes tod_nsec/tod_sec are driven on sys_clk by the ptp clock and
  that evt_pin inputs are asynchronous pins.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "etsr_consts.vh"

// Summary of operation
// RULE1 - sample registers show the unit chosen by pointer bit 8 of unit index
// RULE2 - edge bit 30 reads one for rising edge, zero for falling edge
// RULE3 - seventh sample nanoseconds held in read-only bits 29:0
// RULE4 - seventh sample seconds held in full 32-bit read-only register, reset zero
// RULE5 - 3-bit phase code names 8 ns slot within 40 ns period
// RULE6 - phase codes 000, 001, 010, 011, 100 for 0, 8, 16, 24, 32 ns
// RULE7 - eighth sample has own edge bit, nanoseconds and seconds fields
// RULE8 - eighth sample has 3-bit phase code with same encoding
// RULE9 - reserved bits read zero; writes to sample registers change nothing
module etsr_sample_readout
(
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire [1:0]  evt_pin,
  input  wire [29:0] tod_nsec,
  input  wire [31:0] tod_sec,
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr_stb,
  input  wire        reg_rd_stb,
  output reg  [31:0] reg_rdata_r
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [2:0]  slot_r;
  reg  [2:0]  slot_nxt;
  reg         unit_ptr_r;
  reg  [1:0]  enable_r;
  reg  [1:0]  clear_r;
  reg  [1:0]  clear_nxt;
  reg  [31:0] reg_rdata_nxt;

  wire [7:0]  cnt_all;
  wire [1:0]  pol7_all;
  wire [59:0] ns7_all;
  wire [63:0] sec7_all;
  wire [5:0]  ph7_all;
  wire [1:0]  pol8_all;
  wire [59:0] ns8_all;
  wire [63:0] sec8_all;
  wire [5:0]  ph8_all;

  // selected unit view
  wire [3:0]  sel_cnt;
  wire        sel_pol7;
  wire [29:0] sel_ns7;
  wire [31:0] sel_sec7;
  wire [2:0]  sel_ph7;
  wire        sel_pol8;
  wire [29:0] sel_ns8;
  wire [31:0] sel_sec8;
  wire [2:0]  sel_ph8;

  // ****************************************************************
  // phase slot counter
  // ****************************************************************
  // five 8 ns cycles of sys_clk make one 40 ns period of the 25 MHz
  // clock; the count value is directly the phase code, so 16 ns reads
  // 010 and codes 101-111 are never produced
  always @*
  begin
    if (slot_r == `ETSR_SLOT_LAST)
    begin
      slot_nxt = `ETSR_ZERO3;                    // RULE6
    end
    else
    begin
      slot_nxt = slot_r + 3'h1;                  // RULE6
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slot_r <= `ETSR_ZERO3;
    end
    else
    begin
      slot_r <= slot_nxt;                        // RULE5
    end
  end

  // ****************************************************************
  // timestamp units
  // ****************************************************************
  // one unit per event pin; the pin synchroniser adds three cycles of
  // fixed latency which software may subtract if it needs to
  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1)
    begin : g_unit
      etsr_capture_unit u_cap
      (
        .sys_clk                    (sys_clk),
        .arst_n                     (arst_n),
        .evt_pin                    (evt_pin[u]),
        .cap_enable                 (enable_r[u]),
        .cap_clear                  (clear_r[u]),
        .tod_nsec                   (tod_nsec),
        .tod_sec                    (tod_sec),
        .phase_slot                 (slot_r),
        .edge_cnt_r                 (cnt_all[u*4 +: 4]),
        .seventh_edge_polarity      (pol7_all[u]),
        .seventh_capture_nanosec    (ns7_all[u*30 +: 30]),
        .seventh_capture_sec        (sec7_all[u*32 +: 32]),
        .seventh_capture_phase_slot (ph7_all[u*3 +: 3]),
        .eighth_edge_polarity       (pol8_all[u]),
        .eighth_capture_nanosec     (ns8_all[u*30 +: 30]),
        .eighth_capture_sec         (sec8_all[u*32 +: 32]),
        .eighth_capture_phase_slot  (ph8_all[u*3 +: 3])
      );
    end
  endgenerate

  // ****************************************************************
  // unit selection
  // ****************************************************************
  // every sample register follows the pointer, phase ones included
  assign sel_cnt  = cnt_all[unit_ptr_r*4 +: 4];
  assign sel_pol7 = pol7_all[unit_ptr_r];        // RULE1
  assign sel_ns7  = ns7_all[unit_ptr_r*30 +: 30]; // RULE1
  assign sel_sec7 = sec7_all[unit_ptr_r*32 +: 32]; // RULE1
  assign sel_ph7  = ph7_all[unit_ptr_r*3 +: 3];
  assign sel_pol8 = pol8_all[unit_ptr_r];        // RULE1
  assign sel_ns8  = ns8_all[unit_ptr_r*30 +: 30]; // RULE1
  assign sel_sec8 = sec8_all[unit_ptr_r*32 +: 32]; // RULE1
  assign sel_ph8  = ph8_all[unit_ptr_r*3 +: 3];

  // ****************************************************************
  // writable control registers
  // ****************************************************************
  // clear bits are one-cycle pulses and always read back as zero
  always @*
  begin
    clear_nxt = 2'h0;
    if (reg_wr_stb && (reg_addr == `ETSR_OFF_CTRL))
    begin
      clear_nxt = reg_wdata[`ETSR_CTRL_CLR_LSB +: 2];
    end
  end

  // only pointer and control are writable; sample offsets fall through
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      unit_ptr_r <= 1'b0;
      enable_r   <= `ETSR_ENABLE_RST;
      clear_r    <= 2'h0;
    end
    else
    begin
      clear_r <= clear_nxt;
      if (reg_wr_stb && (reg_addr == `ETSR_OFF_UNIT_INDEX))
      begin
        unit_ptr_r <= reg_wdata[`ETSR_UNIT_PTR_BIT]; // RULE1
      end
      if (reg_wr_stb && (reg_addr == `ETSR_OFF_CTRL))
      begin
        enable_r <= reg_wdata[1:0];
      end
    end
  end

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  // unmapped offsets and reserved bits read as zero
  always @*
  begin
    reg_rdata_nxt = `ETSR_ZERO32;                // RULE9
    case (reg_addr)
      `ETSR_OFF_UNIT_INDEX:
      begin
        reg_rdata_nxt[`ETSR_UNIT_PTR_BIT] = unit_ptr_r;
      end
      `ETSR_OFF_S7_NS:
      begin
        reg_rdata_nxt[`ETSR_EDGE_BIT]      = sel_pol7; // RULE2
        reg_rdata_nxt[`ETSR_NS_MSB:0]      = sel_ns7;  // RULE3
      end
      `ETSR_OFF_S7_SEC:
      begin
        reg_rdata_nxt = sel_sec7;                      // RULE4
      end
      `ETSR_OFF_S7_PHASE:
      begin
        reg_rdata_nxt[`ETSR_PHASE_MSB:0]   = sel_ph7;  // RULE5
      end
      `ETSR_OFF_S8_NS:
      begin
        reg_rdata_nxt[`ETSR_EDGE_BIT]      = sel_pol8; // RULE7
        reg_rdata_nxt[`ETSR_NS_MSB:0]      = sel_ns8;  // RULE7
      end
      `ETSR_OFF_S8_SEC:
      begin
        reg_rdata_nxt = sel_sec8;                      // RULE7
      end
      `ETSR_OFF_S8_PHASE:
      begin
        reg_rdata_nxt[`ETSR_PHASE_MSB:0]   = sel_ph8;  // RULE8
      end
      `ETSR_OFF_CTRL:
      begin
        reg_rdata_nxt[1:0] = enable_r;
      end
      `ETSR_OFF_STATUS:
      begin
        reg_rdata_nxt[`ETSR_CNT_MSB:0] = sel_cnt;
      end
      default:
      begin
        reg_rdata_nxt = `ETSR_ZERO32;                  // RULE9
      end
    endcase
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata_r <= `ETSR_ZERO32;
    end
    else if (reg_rd_stb)
    begin
      reg_rdata_r <= reg_rdata_nxt;
    end
    else
    begin
      reg_rdata_r <= `ETSR_ZERO32;
    end
  end

endmodule // etsr_sample_readout
`default_nettype wire
